//--- logic/bpb_pkg.sv
// holds constants and types shared by the bank configuration block
// assumes one 200 MHz clock and byte-wide register access by offset
package bpb_pkg;

  // ---------------------------------------------------------------
  // register offsets and widths
  // ---------------------------------------------------------------
  localparam int          REG_W             = 8;
  localparam logic [7:0]  OFS_PWM_B         = 8'h14;
  localparam logic [7:0]  OFS_PWM_C         = 8'h15;
  localparam logic [7:0]  OFS_BRIGHT_A      = 8'h16;
  localparam logic [7:0]  OFS_BRIGHT_B      = 8'h18;

  // ---------------------------------------------------------------
  // field layouts, masks and reset values
  // ---------------------------------------------------------------
  localparam int          NUM_ZONES         = 5;
  localparam int          NUM_SINKS         = 3;
  localparam int          NUM_PWM_BANKS     = 2;
  localparam int          PWM_SEL_BIT       = 0;
  localparam int          PWM_POL_BIT       = 1;
  localparam int          PWM_ZONE_LSB      = 2;
  localparam int          BRT_CTL_BIT       = 0;
  localparam int          BRT_MAP_BIT       = 1;
  localparam int          BRT_PTR_LSB       = 2;
  localparam logic [7:0]  PWM_WR_MASK       = 8'h7F;
  localparam logic [7:0]  BRT_WR_MASK       = 8'h1F;
  localparam logic [6:0]  PWM_RESET         = 7'h02;
  localparam logic [4:0]  BRT_RESET         = 5'h11;
  localparam logic [2:0]  MAX_ZONE          = 3'h4;
  localparam logic [2:0]  TARGET_FOUR       = 3'h4;

  // sink bank assignment codes, upper bit set means bank c
  localparam logic [1:0]  ASSIGN_BANK_A     = 2'h0;
  localparam logic [1:0]  ASSIGN_BANK_B     = 2'h1;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [NUM_ZONES-1:0] zoneEnable;   // bit 0 is zone 0
    logic                 polarityHigh;
    logic                 selectSecond;
  } bpb_pwm_cfg_t;

  typedef struct packed {
    logic [2:0] pointer;
    logic       linearMap;
    logic       i2cControl;
  } bpb_bright_cfg_t;

  typedef struct packed {
    logic       pwmGate;
    logic       i2cControl;
    logic       linearMap;
    logic [2:0] target;
  } bpb_sink_ctl_t;

endpackage : bpb_pkg

//--- logic/bpb_pwm_gate.sv
// holds the per-bank pulse input selection, polarity and zone gating
// assumes pulse inputs are already synchronised to sys_clk
`timescale 1ns/1ps
`default_nettype none
module bpb_pwm_gate
  import bpb_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire bpb_pwm_cfg_t cfg,
  input  wire logic         pulseOne,
  input  wire logic         pulseTwo,
  input  wire logic [2:0]   ambientZone,
  output logic              gatedPulse
);

  // ---------------------------------------------------------------
  // gating
  // ---------------------------------------------------------------
  logic gated_reg;
  logic gated_next;
  logic srcPulse;
  logic actPulse;
  logic zoneOn;

  // disabled zone leaves current ungated (full on), never forced off
  always_comb begin
    srcPulse   = cfg.selectSecond ? pulseTwo : pulseOne;
    actPulse   = cfg.polarityHigh ? srcPulse : ~srcPulse;
    zoneOn     = (ambientZone <= MAX_ZONE) &&
                 cfg.zoneEnable[ambientZone];
    gated_next = zoneOn ? actPulse : 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      gated_reg <= 1'b1;
    end else begin
      gated_reg <= gated_next;
    end
  end

  assign gatedPulse = gated_reg;

endmodule // bpb_pwm_gate
`default_nettype wire

//--- logic/bpb_config_bank.sv
// holds the bank pulse mapping and brightness configuration registers
// assumes a byte register port decoded upstream, one clock domain
//
// What this block does
// - bank b bit 0 picks pulse input
// - bank c bit 0 picks pulse input
// - bit 1 sets pulse polarity, high default
// - five zone enable bits, all off default
// - bank a bit 0: sensing or i2c
// - bank b bit 0: sensing or i2c
// - bit 1 exponential or linear current mapping
// - bank a pointer picks target, 1xx four
// - bank b pointer decodes the same way
// - pointer used only under i2c control
// - each sink follows its assigned bank
`timescale 1ns/1ps
`default_nettype none
module bpb_config_bank
  import bpb_pkg::*;
(
  input  wire logic                      sys_clk,
  input  wire logic                      nrst,
  input  wire logic                      regWrEn,
  input  wire logic                      regRdEn,
  input  wire logic [7:0]                regAddr,
  input  wire logic [7:0]                regWrData,
  output logic [7:0]                     regRdData,
  output logic                           regRdValid,
  input  wire logic                      firstPulseInput,
  input  wire logic                      secondPulseInput,
  input  wire logic [2:0]                ambientZone,
  input  wire logic [5:0]                sinkAssign,
  input  wire logic                      bankAPulse,
  input  wire bpb_bright_cfg_t           bankCBright,
  output bpb_sink_ctl_t [NUM_SINKS-1:0]  sinkCtl
);

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  bpb_pwm_cfg_t    pwmB_reg,    pwmB_next;
  bpb_pwm_cfg_t    pwmC_reg,    pwmC_next;
  bpb_bright_cfg_t brightA_reg, brightA_next;
  bpb_bright_cfg_t brightB_reg, brightB_next;
  logic [7:0]      pwmWrVal;
  logic [7:0]      brtWrVal;

  // unused upper bits are masked away, so they never store
  always_comb begin
    pwmWrVal     = regWrData & PWM_WR_MASK;
    brtWrVal     = regWrData & BRT_WR_MASK;
    pwmB_next    = pwmB_reg;
    pwmC_next    = pwmC_reg;
    brightA_next = brightA_reg;
    brightB_next = brightB_reg;
    if (regWrEn) begin
      unique case (regAddr)
        OFS_PWM_B:    pwmB_next    = pwmWrVal[6:0];
        OFS_PWM_C:    pwmC_next    = pwmWrVal[6:0];
        OFS_BRIGHT_A: brightA_next = brtWrVal[4:0];
        OFS_BRIGHT_B: brightB_next = brtWrVal[4:0];
        default:      ;
      endcase
    end
  end

  // reset values give i2c control, exponential map, target four
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pwmB_reg    <= PWM_RESET;
      pwmC_reg    <= PWM_RESET;
      brightA_reg <= BRT_RESET;
      brightB_reg <= BRT_RESET;
    end else begin
      pwmB_reg    <= pwmB_next;
      pwmC_reg    <= pwmC_next;
      brightA_reg <= brightA_next;
      brightB_reg <= brightB_next;
    end
  end

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  logic [7:0] rdData_reg,  rdData_next;
  logic       rdValid_reg, rdValid_next;

  // one cycle latency; unmapped offsets answer zero
  always_comb begin
    rdValid_next = regRdEn;
    rdData_next  = rdData_reg;
    if (regRdEn) begin
      unique case (regAddr)
        OFS_PWM_B:    rdData_next = {1'b0, pwmB_reg};
        OFS_PWM_C:    rdData_next = {1'b0, pwmC_reg};
        OFS_BRIGHT_A: rdData_next = {3'h0, brightA_reg};
        OFS_BRIGHT_B: rdData_next = {3'h0, brightB_reg};
        default:      rdData_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rdData_reg  <= 8'h00;
      rdValid_reg <= 1'b0;
    end else begin
      rdData_reg  <= rdData_next;
      rdValid_reg <= rdValid_next;
    end
  end

  assign regRdData  = rdData_reg;
  assign regRdValid = rdValid_reg;

  // ---------------------------------------------------------------
  // pulse pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] pinMeta_reg, pinMeta_next;
  logic [1:0] pinSync_reg, pinSync_next;

  // meta stage feeds only the sync stage
  always_comb begin
    pinMeta_next = {secondPulseInput, firstPulseInput};
    pinSync_next = pinMeta_reg;
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pinMeta_reg <= 2'h0;
      pinSync_reg <= 2'h0;
    end else begin
      pinMeta_reg <= pinMeta_next;
      pinSync_reg <= pinSync_next;
    end
  end

  // ---------------------------------------------------------------
  // per-bank pulse gating, index 0 is bank b, 1 is bank c
  // ---------------------------------------------------------------
  bpb_pwm_cfg_t pwmCfgArr [NUM_PWM_BANKS];
  logic [NUM_PWM_BANKS-1:0] gatedArr;

  assign pwmCfgArr[0] = pwmB_reg;
  assign pwmCfgArr[1] = pwmC_reg;

  genvar gb;
  generate
    for (gb = 0; gb < NUM_PWM_BANKS; gb++) begin : g_bank
      bpb_pwm_gate u_gate (
        .sys_clk     (sys_clk),
        .nrst        (nrst),
        .cfg         (pwmCfgArr[gb]),
        .pulseOne    (pinSync_reg[0]),
        .pulseTwo    (pinSync_reg[1]),
        .ambientZone (ambientZone),
        .gatedPulse  (gatedArr[gb])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // sink routing
  // ---------------------------------------------------------------
  // pointer 1xx collapses to target four, lower codes pass through
  function automatic logic [2:0] decodeTarget(input logic [2:0] ptr);
    decodeTarget = ptr[2] ? TARGET_FOUR : {1'b0, ptr[1:0]};
  endfunction

  genvar gs;
  generate
    for (gs = 0; gs < NUM_SINKS; gs++) begin : g_sink
      bpb_sink_ctl_t   ctl_reg, ctl_next;
      bpb_bright_cfg_t brt;
      logic            pwm;
      logic [1:0]      asg;

      // bank a pulse comes gated from elsewhere, three cycles less latency than banks b and c
      always_comb begin
        asg = sinkAssign[2*gs +: 2];
        if (asg == ASSIGN_BANK_A) begin
          brt = brightA_reg;
          pwm = bankAPulse;
        end else if (asg == ASSIGN_BANK_B) begin
          brt = brightB_reg;
          pwm = gatedArr[0];
        end else begin
          brt = bankCBright;
          pwm = gatedArr[1];
        end
        ctl_next.pwmGate    = pwm;
        ctl_next.i2cControl = brt.i2cControl;
        ctl_next.linearMap  = brt.linearMap;
        // sensing mode follows the live zone, pointer unused
        ctl_next.target     = brt.i2cControl ?
                              decodeTarget(brt.pointer) :
                              ambientZone;
      end

      always_ff @(posedge sys_clk) begin
        if (!nrst) begin
          ctl_reg <= '0;
        end else begin
          ctl_reg <= ctl_next;
        end
      end

      assign sinkCtl[gs] = ctl_reg;
    end
  endgenerate

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  logic zoneOnB;
  logic zoneOnC;
  assign zoneOnB = (ambientZone <= MAX_ZONE) &&
                   pwmB_reg.zoneEnable[ambientZone];
  assign zoneOnC = (ambientZone <= MAX_ZONE) &&
                   pwmC_reg.zoneEnable[ambientZone];

  sequence s_b_first_high;
    (!pwmB_reg.selectSecond && pwmB_reg.polarityHigh && zoneOnB &&
     firstPulseInput) [*3];
  endsequence

  sequence s_c_second_high;
    (pwmC_reg.selectSecond && pwmC_reg.polarityHigh && zoneOnC &&
     secondPulseInput) [*3];
  endsequence

  sequence s_b_low_pol;
    (!pwmB_reg.selectSecond && !pwmB_reg.polarityHigh && zoneOnB &&
     firstPulseInput) [*3];
  endsequence

  a_reset_pwm_vals: assert property ($rose(nrst) |->
    pwmB_reg == PWM_RESET && pwmC_reg == PWM_RESET)
    else $error("pulse mapping reset value wrong");

  a_reset_bright_vals: assert property ($rose(nrst) |->
    brightA_reg == BRT_RESET && brightB_reg == BRT_RESET)
    else $error("brightness config reset value wrong");

  a_b_first_src: assert property (s_b_first_high |=>
    gatedArr[0])
    else $error("bank b did not follow first pulse input");

  a_c_second_src: assert property (s_c_second_high |=>
    gatedArr[1])
    else $error("bank c did not follow second pulse input");

  a_b_low_pol: assert property (s_b_low_pol |=>
    !gatedArr[0])
    else $error("active low polarity not applied");

  a_zone_off_c: assert property (!zoneOnC |=>
    gatedArr[1])
    else $error("pulse gated in a disabled zone");

  a_sink_follow_b: assert property (
    sinkAssign[1:0] == ASSIGN_BANK_B |=>
    sinkCtl[0].pwmGate == $past(gatedArr[0]) &&
    sinkCtl[0].linearMap == $past(brightB_reg.linearMap))
    else $error("sink one not following bank b");

  a_target_four_a: assert property (
    sinkAssign[1:0] == ASSIGN_BANK_A && brightA_reg.i2cControl &&
    brightA_reg.pointer[2] |=> sinkCtl[0].target == TARGET_FOUR)
    else $error("bank a pointer 1xx not target four");

  a_target_zero_b: assert property (
    sinkAssign[3:2] == ASSIGN_BANK_B && brightB_reg.i2cControl &&
    brightB_reg.pointer == 3'h0 |=> sinkCtl[1].target == 3'h0)
    else $error("bank b pointer 000 not target zero");

  a_target_als: assert property (
    sinkAssign[1:0] == ASSIGN_BANK_A && !brightA_reg.i2cControl |=>
    sinkCtl[0].target == $past(ambientZone) && !sinkCtl[0].i2cControl)
    else $error("pointer used under sensing control");

  a_unused_zero: assert property (
    regRdEn && regAddr == OFS_BRIGHT_A |=>
    regRdValid && regRdData[7:5] == 3'h0)
    else $error("unused bits read nonzero");

endmodule // bpb_config_bank
`default_nettype wire

//--- tb/bpb_host_model.sv
// host side of the register port: byte writes and reads by offset
// assumes the device answers a read within four cycles of the strobe
`timescale 1ns/1ps
`default_nettype none
module bpb_host_model
  import bpb_pkg::*;
(
  input  wire logic             sys_clk,
  output var  logic             regWrEn,
  output var  logic             regRdEn,
  output var  logic [REG_W-1:0] regAddr,
  output var  logic [REG_W-1:0] regWrData,
  input  wire logic [REG_W-1:0] regRdData,
  input  wire logic             regRdValid
);
  // ---------------------------------------------------------------
  // idle levels, set at time zero so no strobe floats
  // ---------------------------------------------------------------
  initial begin
    regWrEn   = 1'b0;
    regRdEn   = 1'b0;
    regAddr   = 8'h00;
    regWrData = 8'h00;
  end

  // one write strobe, driven off the sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    regWrEn   = 1'b1;
    regAddr   = a;
    regWrData = d;
    @(negedge sys_clk);
    regWrEn   = 1'b0;
  endtask

  // one read strobe; waits a few cycles at most so a dead port is seen
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output bit ok);
    int n;
    @(negedge sys_clk);
    regRdEn = 1'b1;
    regAddr = a;
    @(negedge sys_clk);
    regRdEn = 1'b0;
    ok      = 1'b0;
    n       = 0;
    d       = 8'h00;
    while (!ok && n < 4) begin
      if (regRdValid === 1'b1) begin
        ok = 1'b1;
        d  = regRdData;
      end else begin
        @(negedge sys_clk);
        n++;
      end
    end
  endtask
endmodule // bpb_host_model
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the bank configuration registers
// assumes bpb_config_bank and the host model; inputs move on negedge
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import bpb_pkg::*;
;
  logic                          sys_clk;
  logic                          nrst;
  logic                          regWrEn;
  logic                          regRdEn;
  logic [7:0]                    regAddr;
  logic [7:0]                    regWrData;
  logic [7:0]                    regRdData;
  logic                          regRdValid;
  logic                          firstPulseInput;
  logic                          secondPulseInput;
  logic                          bankAPulse;
  logic [2:0]                    ambientZone;
  logic [5:0]                    sinkAssign;
  bpb_bright_cfg_t               bankCBright;
  bpb_sink_ctl_t [NUM_SINKS-1:0] sinkCtl;
  int                            errors;
  int                            num_checks;
  logic [7:0]                    sh [4];
  logic [7:0] ADDR [4] = '{8'h14, 8'h15, 8'h16, 8'h18};
  logic [7:0] MASK [4] = '{8'h7F, 8'h7F, 8'h1F, 8'h1F};
  logic [5:0] ASSIGN [3] = '{6'h24, 6'h19, 6'h07};

  // ---------------------------------------------------------------
  // design, host and clock
  // ---------------------------------------------------------------
  bpb_config_bank bpb_config_bank_inst (
    .sys_clk(sys_clk), .nrst(nrst), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .regRdValid(regRdValid),
    .firstPulseInput(firstPulseInput),
    .secondPulseInput(secondPulseInput), .ambientZone(ambientZone),
    .sinkAssign(sinkAssign), .bankAPulse(bankAPulse),
    .bankCBright(bankCBright), .sinkCtl(sinkCtl));

  bpb_host_model bpb_host_model_inst (
    .sys_clk(sys_clk), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------
  // expectations worked out from the register meanings
  // ---------------------------------------------------------------
  // disabled or out-of-range zone leaves the bank ungated
  function automatic logic expGate(logic [7:0] c);
    logic [4:0] en;
    en = c[6:2];
    if (ambientZone > 3'h4 || !en[ambientZone]) return 1'b1;
    return (c[0] ? secondPulseInput : firstPulseInput) ~^ c[1];
  endfunction

  function automatic bpb_sink_ctl_t expSink(logic [1:0] a);
    bpb_sink_ctl_t   s;
    bpb_bright_cfg_t b;
    if (a[1]) begin
      b = bankCBright;
      s.pwmGate = expGate(sh[1]);
    end else if (a[0]) begin
      b = bpb_bright_cfg_t'(sh[3][4:0]);
      s.pwmGate = expGate(sh[0]);
    end else begin
      b = bpb_bright_cfg_t'(sh[2][4:0]);
      s.pwmGate = bankAPulse;
    end
    s.i2cControl = b.i2cControl;
    s.linearMap  = b.linearMap;
    s.target = !b.i2cControl ? ambientZone :
               b.pointer[2] ? 3'h4 : {1'b0, b.pointer[1:0]};
    return s;
  endfunction

  // ---------------------------------------------------------------
  // compare tasks and the closing report
  // ---------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk8(logic [7:0] a, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("Error reg %h expected %h seen %h", a, e, g);
    end
  endtask

  task automatic chkSink(int i);
    bpb_sink_ctl_t e;
    e = expSink(sinkAssign[2*i +: 2]);
    num_checks++;
    if (sinkCtl[i] !== e) begin
      errors++;
      $display("Error sinkCtl[%0d] expected %h seen %h", i, e, sinkCtl[i]);
    end
  endtask

  // reads one offset; a dead port counts and ends the run
  task automatic rdChk(logic [7:0] a, logic [7:0] e);
    logic [7:0] d;
    bit         ok;
    bpb_host_model_inst.rd(a, d, ok);
    if (!ok) begin
      errors++;
      $display("Error regRdValid expected 1 seen 0");
      wrap_up();
    end else begin
      chk8(a, e, d);
    end
  endtask

  // upper bits are set on purpose; the shadow keeps only live bits
  task automatic put(int r, logic [7:0] d);
    bpb_host_model_inst.wr(ADDR[r], d);
    sh[r] = d & MASK[r];
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    errors = 0;
    num_checks = 0;
    nrst = 1'b0;
    firstPulseInput = 1'b0;
    secondPulseInput = 1'b0;
    bankAPulse = 1'b0;
    ambientZone = 3'h0;
    sinkAssign = 6'h24;
    bankCBright = bpb_bright_cfg_t'(5'h00);
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst = 1'b1;
    sh = '{8'h02, 8'h02, 8'h11, 8'h11};
    // reset values, then unmapped offsets read as zero
    for (int r = 0; r < 4; r++) rdChk(ADDR[r], sh[r]);
    rdChk(8'h17, 8'h00);
    rdChk(8'h13, 8'h00);
    // sweep selections, polarities, zones, pointers and assignments
    for (int k = 0; k < 16; k++) begin
      put(0, {1'b1, k[2] ? 5'h15 : 5'h0A, k[1], k[0]});
      put(1, {1'b1, k[2] ? 5'h0A : 5'h15, k[3], ~k[0]});
      put(2, {3'h7, 3'(k), k[3], k[0] ^ k[1]});
      put(3, {3'h7, ~3'(k), k[0], ~k[3]});
      firstPulseInput = k[1] ^ k[3];
      secondPulseInput = k[2] ^ k[0];
      bankAPulse = k[2];
      ambientZone = 3'(k);
      sinkAssign = ASSIGN[k % 3];
      bankCBright = bpb_bright_cfg_t'(5'(k * 7));
      // pin path is four cycles deep; six leaves margin
      repeat (6) @(negedge sys_clk);
      for (int i = 0; i < 3; i++) chkSink(i);
      for (int r = 0; r < 4; r++) rdChk(ADDR[r], sh[r]);
    end
    // exact pin-to-output latency on bank b, all zones enabled
    put(0, 8'h7E);
    sinkAssign = 6'h01;
    ambientZone = 3'h0;
    firstPulseInput = 1'b0;
    repeat (6) @(negedge sys_clk);
    firstPulseInput = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk8(8'h14, 8'h00, {7'h00, sinkCtl[0].pwmGate});
    @(negedge sys_clk);
    chk8(8'h14, 8'h01, {7'h00, sinkCtl[0].pwmGate});
    // bank c on the second input, bank b pointer at target zero
    put(1, 8'h7F);
    put(3, 8'h01);
    sinkAssign = 6'h25;
    secondPulseInput = 1'b1;
    repeat (6) @(negedge sys_clk);
    for (int i = 0; i < 3; i++) chkSink(i);
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
